// File: hdl/tcc_pkg.sv
// Package: constants for the timed capture and compare unit
package tcc_pkg;
  // Register indices (byte locations)
  localparam logic [7:0] CAP_TIME_LO_ADDR = 8'h04;
  localparam logic [7:0] CAP_TIME_HI_ADDR = 8'h05;
  localparam logic [7:0] CAP_STATUS_ADDR = 8'h06;
  localparam logic [7:0] CMP_TIME_LO_ADDR = 8'h04;
  localparam logic [7:0] CMP_TIME_HI_ADDR = 8'h05;
  localparam logic [7:0] CMP_COMMAND_ADDR = 8'h06;
  localparam logic [7:0] TIMER_FLAG_ADDR = 8'h16;
  localparam logic [7:0] OUT_STATUS_ADDR = 8'h15;
  localparam logic [7:0] IO_CONTROL_ONE_ADDR = 8'h17;
  localparam logic [7:0] TIMER_ONE_ADDR = 8'h0a;
  // Field positions
  localparam int FIFO_SIX_BIT = 6;
  localparam int FIFO_AVAIL_BIT = 7;
  localparam int CAM_FULL_BIT = 6;
  localparam int HOLD_BUSY_BIT = 7;
  localparam int OUT4_EN_BIT = 4;
  localparam int OUT5_EN_BIT = 6;
  localparam int TAG_T2_BIT = 6;
  localparam int TAG_SET_BIT = 5;
  localparam int TAG_INT_BIT = 4;
  // Sizes and counts
  localparam int CAM_DEPTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_SIX_LEVEL = 4'h6;
  localparam logic [2:0] STATE_TIMES_PER_TICK = 3'h7;
  localparam logic [7:0] IO_CONTROL_ONE_RESET = 8'h00;
  // Command channels
  localparam logic [3:0] CH_CLEAR_T2 = 4'he;
  localparam logic [3:0] CH_AD_START = 4'hf;
endpackage

// File: hdl/timed_capture_compare_unit.sv
// Timed capture unit and CAM-based compare scheduler
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Flag status bit 6 high while capture FIFO holds six or more records.
// - Flag status bit 7 high when a record waits in the holding register.
// - Reading flag status clears its bits 0 through 5.
// - Reading capture time high byte (05h) pops one level; read status first.
// - Capture status at 06h, capture time at 04h and 05h.
// - Empty read gives arbitrary time and events, true pin levels.
// - Status has per-pin pairs: low bit event, high bit present level.
// - Up to eight pending events: A/D start, timer two clear, flags, pins.
// - Control one bits 4 and 6 turn shared pins into outputs.
// - Pin commands raise execution interrupt; others raise software timer one.
// - One CAM entry compared per state time, all eight every 8.
// - Each CAM entry is 16-bit time plus 7-bit command tag.
// - Channels 8 to 0Fh ignore tag bit 5.
// - Tag write then time write loads holding register with both.
// - Holding register never executes; moves to free entry; may be overwritten.
// - Status bit 6 low when holding empty and entry free; bit 7 holding full.
// - All entries evaluated before acting; opposite pin commands cancel.
// - An entry stays occupied until its timer matches or reset.
// - Internal events are not aligned and cannot be cancelled.
// - Timer one ticks every 8 state times; timer two on both edges, once per 8.
// - Each capture with fewer than eight queued pushes the timer one value and four event bits.
module timed_capture_compare_unit
  import tcc_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [3:0] CAPTURE_EVENT_IN,
  input wire logic [3:0] CAPTURE_PIN_IN,
  input wire logic COUNTER_TWO_CLK_IN,
  input wire logic COUNTER_TWO_CLEAR_PIN_IN,
  output logic [7:0] RDATA_OUT,
  output logic [5:0] TIMED_PIN_OUT,
  output logic [1:0] TIMED_PIN_OE_OUT,
  output logic AD_START_OUT,
  output logic EXEC_IRQ_OUT,
  output logic SOFT_TIMER_IRQ_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] t1;
    logic [15:0] t2;
    logic [2:0] pre;
    logic t2_in;
    logic t2_pend;
    logic [2:0] scan;
    logic [7:0] valid;
    logic [7:0][22:0] cam;
    logic [7:0] match;
    logic [22:0] hold;
    logic hold_full;
    logic [6:0] tag;
    logic [7:0] wtime_lo;
    logic [7:0][19:0] fifo;
    logic [3:0] fcount;
    logic [19:0] cap_hold;
    logic cap_full;
    logic [5:0] flags;
    logic [7:0] io_control_one;
    logic [5:0] pins;
    logic ad;
    logic eirq;
    logic sirq;
    logic [7:0] rdata;
  } state_s;

  state_s q, d;
  logic [15:0] ref_t;
  logic [22:0] ent;
  logic [3:0] ch;
  logic [5:0] set_m;
  logic [5:0] clr_m;
  logic [2:0] free_idx;
  logic free_any;
  logic pop;
  logic push;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ent = '0;
    ch = '0;
    ref_t = '0;
    set_m = '0;
    clr_m = '0;
    free_idx = '0;
    free_any = 1'b0;
    d.ad = 1'b0;
    d.eirq = 1'b0;
    d.sirq = 1'b0;
    d.rdata = 8'h00;
    pop = 1'b0;
    push = 1'b0;

    // Timer one prescaler, timer two edge counter
    d.pre = q.pre + 3'h1;
    if (q.pre == STATE_TIMES_PER_TICK) begin
      d.t1 = q.t1 + 16'h0001;
    end
    d.t2_in = COUNTER_TWO_CLK_IN;
    if (d.t2_in != q.t2_in) begin
      d.t2_pend = 1'b1;
    end
    // Edge is held until the tick so timer two moves at most once per 8
    if (q.pre == STATE_TIMES_PER_TICK && q.t2_pend) begin
      d.t2 = q.t2 + 16'h0001;
      d.t2_pend = 1'b0;
    end
    if (COUNTER_TWO_CLEAR_PIN_IN) begin
      d.t2 = 16'h0000;
    end

    // Scan one entry per state time
    d.scan = q.scan + 3'h1;
    ent = q.cam[q.scan];
    ref_t = ent[TAG_T2_BIT] ? q.t2 : q.t1;
    if (q.valid[q.scan] && ent[22:7] == ref_t) begin
      ch = ent[3:0];
      if (ch[3]) begin
        // Internal event fires right away, not cancellable
        d.valid[q.scan] = 1'b0;
        if (ch == CH_CLEAR_T2) begin
          d.t2 = 16'h0000;
        end
        if (ch == CH_AD_START) begin
          d.ad = 1'b1;
        end
        d.sirq = ent[TAG_INT_BIT];
      end else begin
        d.match[q.scan] = 1'b1;
      end
    end

    // After a full pass act on all pin matches together
    if (q.scan == 3'h7) begin
      for (int i = 0; i < CAM_DEPTH; i++) begin
        if (d.match[i]) begin
          if (q.cam[i][3:0] < 4'h6) begin
            if (q.cam[i][TAG_SET_BIT]) begin
              set_m[q.cam[i][2:0]] = 1'b1;
            end else begin
              clr_m[q.cam[i][2:0]] = 1'b1;
            end
          end else if (q.cam[i][3:0] == 4'h6) begin
            set_m[2:0] = set_m[2:0] | {3{q.cam[i][TAG_SET_BIT]}};
            clr_m[2:0] = clr_m[2:0] | {3{~q.cam[i][TAG_SET_BIT]}};
          end else begin
            set_m[5:3] = set_m[5:3] | {3{q.cam[i][TAG_SET_BIT]}};
            clr_m[5:3] = clr_m[5:3] | {3{~q.cam[i][TAG_SET_BIT]}};
          end
          if (q.cam[i][TAG_INT_BIT]) begin
            d.eirq = 1'b1;
          end
          d.valid[i] = 1'b0;
        end
      end
      d.match = '0;
      // Opposite commands on one pin cancel
      d.pins = (q.pins | (set_m & ~clr_m)) & ~(clr_m & ~set_m);
    end

    // Holding register into a free entry
    for (int i = CAM_DEPTH - 1; i >= 0; i--) begin
      if (!q.valid[i]) begin
        free_any = 1'b1;
        free_idx = i[2:0];
      end
    end
    // Loading only in the entry's own scan slot keeps one write per entry
    if (q.hold_full && free_any && free_idx == q.scan) begin
      d.cam[free_idx] = q.hold;
      d.valid[free_idx] = 1'b1;
      d.match[free_idx] = 1'b0;
      d.hold_full = 1'b0;
    end

    // Capture FIFO
    push = |CAPTURE_EVENT_IN && q.fcount < 4'h8;
    if (!q.cap_full && q.fcount != 4'h0) begin
      d.cap_hold = q.fifo[0];
      d.cap_full = 1'b1;
      pop = 1'b1;
    end

    // Register bus
    if (WR_IN) begin
      case (ADDR_IN)
        CMP_COMMAND_ADDR: d.tag = WDATA_IN[6:0];
        CMP_TIME_LO_ADDR: d.wtime_lo = WDATA_IN;
        CMP_TIME_HI_ADDR: begin
          // Overwrites any command still waiting
          d.hold = {WDATA_IN, q.wtime_lo, q.tag};
          d.hold_full = 1'b1;
        end
        IO_CONTROL_ONE_ADDR: d.io_control_one = WDATA_IN;
        default: d.io_control_one = q.io_control_one;
      endcase
    end
    if (RD_IN) begin
      case (ADDR_IN)
        CAP_TIME_LO_ADDR: d.rdata = q.cap_hold[7:0];
        CAP_TIME_HI_ADDR: begin
          d.rdata = q.cap_hold[15:8];
          d.cap_full = pop;
        end
        CAP_STATUS_ADDR: begin
          // Pin level bits always live; event bits stale if empty
          d.rdata = {CAPTURE_PIN_IN[3], q.cap_hold[19],
                     CAPTURE_PIN_IN[2], q.cap_hold[18],
                     CAPTURE_PIN_IN[1], q.cap_hold[17],
                     CAPTURE_PIN_IN[0], q.cap_hold[16]};
        end
        TIMER_FLAG_ADDR: begin
          // Bit 7 record ready, bit 6 six or more queued
          d.rdata = {q.cap_full, (q.fcount >= FIFO_SIX_LEVEL), q.flags};
          d.flags = '0;
        end
        OUT_STATUS_ADDR: begin
          d.rdata = {q.hold_full, q.hold_full | ~free_any, q.pins};
        end
        TIMER_ONE_ADDR: d.rdata = q.t1[7:0];
        IO_CONTROL_ONE_ADDR: d.rdata = q.io_control_one;
        default: d.rdata = 8'h00;
      endcase
    end

    // FIFO shift and push
    if (pop) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        d.fifo[i] = q.fifo[i + 1];
      end
    end
    if (push) begin
      d.fifo[q.fcount - {3'h0, pop}] = {CAPTURE_EVENT_IN, q.t1};
    end
    d.fcount = q.fcount + {3'h0, push} - {3'h0, pop};

    // Software flags set after read clear: set wins
    if (q.valid[q.scan] && ent[22:7] == ref_t && ent[3:2] == 2'b10) begin
      d.flags[ent[1:0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      q <= '0;
    end else if (CLK_EN_IN) begin
      q <= d;
    end
  end

  always_comb begin
    RDATA_OUT = q.rdata;
    TIMED_PIN_OUT = q.pins;
    TIMED_PIN_OE_OUT = {q.io_control_one[OUT5_EN_BIT], q.io_control_one[OUT4_EN_BIT]};
    AD_START_OUT = q.ad;
    EXEC_IRQ_OUT = q.eirq;
    SOFT_TIMER_IRQ_OUT = q.sirq;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fifo_six_flag: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) RD_IN && CLK_EN_IN && ADDR_IN == TIMER_FLAG_ADDR
    |=> RDATA_OUT[FIFO_SIX_BIT] == ($past(q.fcount) >= FIFO_SIX_LEVEL))
    else $error("fifo six flag wrong");
  a_flag_read_clears: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) RD_IN && CLK_EN_IN && ADDR_IN == TIMER_FLAG_ADDR
    && !(q.valid[q.scan]) |=> q.flags == 6'h00)
    else $error("flags not cleared");
  a_scan_advances: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) CLK_EN_IN |=> q.scan == $past(q.scan) + 3'h1)
    else $error("scan stalled");
  a_timer_one_tick: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) CLK_EN_IN && q.pre != STATE_TIMES_PER_TICK
    |=> $stable(q.t1))
    else $error("timer one moved early");
  a_hold_write: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) WR_IN && CLK_EN_IN && ADDR_IN == CMP_TIME_HI_ADDR
    |=> q.hold[6:0] == $past(q.tag))
    else $error("hold tag wrong");
  a_hold_status: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) RD_IN && CLK_EN_IN && ADDR_IN == OUT_STATUS_ADDR
    |=> RDATA_OUT[HOLD_BUSY_BIT] == $past(q.hold_full))
    else $error("hold status wrong");
  a_pin_enable: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) 1'b1 |-> TIMED_PIN_OE_OUT[0] == q.io_control_one[OUT4_EN_BIT])
    else $error("pin enable wrong");
  a_entry_stays: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) CLK_EN_IN && q.valid[0] && q.match[0] == 1'b0
    && !(q.scan == 3'h0) |=> q.valid[0])
    else $error("entry dropped");

  // Bus request shapes shared by the checks below
  sequence s_flag_read;
    RD_IN && CLK_EN_IN && ADDR_IN == TIMER_FLAG_ADDR;
  endsequence
  sequence s_time_hi_read;
    RD_IN && CLK_EN_IN && ADDR_IN == CAP_TIME_HI_ADDR;
  endsequence
  sequence s_status_read;
    RD_IN && CLK_EN_IN && ADDR_IN == CAP_STATUS_ADDR;
  endsequence
  sequence s_out_status_read;
    RD_IN && CLK_EN_IN && ADDR_IN == OUT_STATUS_ADDR;
  endsequence

  a_fifo_avail_flag: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) s_flag_read
    |=> RDATA_OUT[FIFO_AVAIL_BIT] == $past(q.cap_full))
    else $error("fifo ready flag wrong");
  // Last record popped with nothing behind it leaves the holder empty
  a_time_read_pops: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) s_time_hi_read and q.cap_full
    && q.fcount == 4'h0 |=> !q.cap_full)
    else $error("time read did not pop");
  a_pin_levels: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) s_status_read
    |=> RDATA_OUT[7] == $past(CAPTURE_PIN_IN[3])
    && RDATA_OUT[1] == $past(CAPTURE_PIN_IN[0]))
    else $error("pin level bits wrong");
  a_cam_status: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) s_out_status_read
    |=> RDATA_OUT[CAM_FULL_BIT] == ($past(q.hold_full) || $past(&q.valid)))
    else $error("cam status wrong");
  // A parked command must wait for a free entry, never act on its own
  a_hold_waits: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) CLK_EN_IN && q.hold_full && !free_any
    |=> q.hold_full)
    else $error("hold left early");
  a_read_strobe_only: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) CLK_EN_IN && !RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data outside read");
  a_timer_two_rate: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) CLK_EN_IN && q.pre != STATE_TIMES_PER_TICK
    && !COUNTER_TWO_CLEAR_PIN_IN
    && !(q.valid[q.scan] && ent[3:0] == CH_CLEAR_T2) |=> $stable(q.t2))
    else $error("timer two moved early");
  // Pin actions only land once the full pass has been evaluated
  a_exec_at_pass: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) EXEC_IRQ_OUT |-> q.scan == 3'h0)
    else $error("exec pulse off pass");
  a_pins_at_pass: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) $changed(TIMED_PIN_OUT) |-> q.scan == 3'h0)
    else $error("pins moved off pass");
endmodule
`default_nettype wire

// File: bench/pin_partner.sv
// Pin-side model: capture inputs, counter two pins, shared pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic clk_in,
  input wire logic [3:0] edge_req_in,
  input wire logic [5:0] timed_pin_in,
  input wire logic [1:0] timed_oe_in,
  output logic [3:0] event_out,
  output logic [3:0] level_out,
  output logic t2_clk_out,
  output logic t2_clear_out
);
  logic [3:0] lvl = 4'h0;
  logic [3:0] ev_q = 4'h0;
  assign event_out = ev_q;
  // Shared wires follow the unit once it drives them
  assign level_out = {timed_oe_in[1] ? timed_pin_in[5] : lvl[3],
    timed_oe_in[0] ? timed_pin_in[4] : lvl[2], lvl[1:0]};
  // Counter two pins stay quiet, so a timer two match never comes
  assign t2_clk_out = 1'b0;
  assign t2_clear_out = 1'b0;
  // Each requested edge flips the pin and flags it for one cycle
  always @(posedge clk_in) begin
    lvl <= lvl ^ edge_req_in;
    ev_q <= edge_req_in;
  end
endmodule
`default_nettype wire

// File: bench/tb_timed_capture_compare_unit.sv
// Self-checking bench for the timed capture and compare unit
`timescale 1ns/1ns
`default_nettype none
module tb_timed_capture_compare_unit
  import tcc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_s, rd_s, t2c, t2r, ad, xirq, sirq;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] edge_req, ev, lvl, lv;
  logic [5:0] tpin;
  logic [1:0] toe;
  logic [15:0] t;
  logic [3:0] ms [7];
  int fails = 0, cmp_count = 0, cyc = 0, n_x = 0, n_s = 0, n_a = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= rst ? 0 : cyc + 1;
    n_x <= n_x + (xirq === 1'b1);
    n_s <= n_s + (sirq === 1'b1);
    n_a <= n_a + (ad === 1'b1);
  end
  timed_capture_compare_unit timed_capture_compare_unit_i (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
    .CAPTURE_EVENT_IN(ev), .CAPTURE_PIN_IN(lvl),
    .COUNTER_TWO_CLK_IN(t2c), .COUNTER_TWO_CLEAR_PIN_IN(t2r),
    .RDATA_OUT(rdata), .TIMED_PIN_OUT(tpin), .TIMED_PIN_OE_OUT(toe),
    .AD_START_OUT(ad), .EXEC_IRQ_OUT(xirq), .SOFT_TIMER_IRQ_OUT(sirq));
  pin_partner pin_partner_i (.clk_in(clk), .edge_req_in(edge_req),
    .timed_pin_in(tpin), .timed_oe_in(toe), .event_out(ev),
    .level_out(lvl), .t2_clk_out(t2c), .t2_clear_out(t2r));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  function automatic logic [7:0] st(input logic [3:0] e, l);
    for (int i = 0; i < 4; i++) st[2*i +: 2] = {l[i], e[i]};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rc(input logic [7:0] a, m, e);
    logic [7:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask
  // Commands are spaced so the holding register can drain
  task automatic cmd(input logic [7:0] tag, input logic [15:0] tm);
    wr(CMP_COMMAND_ADDR, tag);
    wr(CMP_TIME_LO_ADDR, tm[7:0]);
    wr(CMP_TIME_HI_ADDR, tm[15:8]);
    repeat (8) @(posedge clk);
  endtask
  task automatic fire(input logic [3:0] m);
    @(posedge clk);
    edge_req <= m;
    @(posedge clk);
    edge_req <= 4'h0;
    lv = lv ^ m;
    repeat (8) @(posedge clk);
  endtask
  task automatic pop(output logic [7:0] s);
    rd(CAP_STATUS_ADDR, s);
    rd(CAP_TIME_LO_ADDR, d);
    rd(CAP_TIME_HI_ADDR, d);
    repeat (8) @(posedge clk);
  endtask
  task automatic wt(ref int n, input int want);
    for (int i = 0; i < 200 && n < want; i++) @(posedge clk);
    if (n < want) begin
      fails++;
      test_done();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int c;
    {addr, wdata, wr_s, rd_s, edge_req, lv} = '0;
    void'($urandom(32'h0939b562));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rc(OUT_STATUS_ADDR, 8'hc0, 8'h00);
    rc(8'h30, 8'hff, 8'h00);
    rc(TIMER_FLAG_ADDR, 8'hc0, 8'h00);
    ms[0] = 4'($urandom_range(15, 1));
    fire(ms[0]);
    rc(TIMER_FLAG_ADDR, 8'hc0, 8'h80);
    rc(CAP_STATUS_ADDR, 8'hff, st(ms[0], lv));
    rd(CAP_TIME_LO_ADDR, d);
    rc(CAP_TIME_HI_ADDR, 8'hff, 8'h00);
    repeat (8) @(posedge clk);
    rc(TIMER_FLAG_ADDR, 8'h80, 8'h00);
    rc(CAP_STATUS_ADDR, 8'haa, st(4'h0, lv));
    for (c = 0; c < 7; c++) begin
      ms[c] = 4'($urandom_range(15, 1));
      fire(ms[c]);
    end
    rc(TIMER_FLAG_ADDR, 8'hc0, 8'hc0);
    for (c = 0; c < 7; c++) begin
      pop(d);
      chk(d, st(ms[c], lv));
      if (c == 1) rc(TIMER_FLAG_ADDR, 8'h40, 8'h00);
    end
    rc(TIMER_FLAG_ADDR, 8'h80, 8'h00);
    wr(IO_CONTROL_ONE_ADDR, 8'h50);
    @(posedge clk);
    #1 chk({6'h0, toe}, 8'h03);
    for (c = 0; c < 8; c++) begin
      cmd(8'h10 | 8'(c) | (c < 6 ? 8'h20 : 8'h00), 16'(cyc / 8 + 6));
      wt(n_x, c + 1);
      repeat (2) @(posedge clk);
      chk({2'h0, tpin}, c < 6 ? 8'((1 << (c + 1)) - 1) :
        (c == 6 ? 8'h38 : 8'h00));
    end
    // Opposite pairs written in both orders, so write order cannot pass
    t = 16'(cyc / 8 + 9);
    cmd(8'h20, t);
    cmd(8'h00, t);
    cmd(8'h01, t);
    cmd(8'h21, t);
    repeat (100) @(posedge clk);
    chk({2'h0, tpin}, 8'h00);
    rc(OUT_STATUS_ADDR, 8'hc0, 8'h00);
    for (c = 0; c < 6; c++) begin
      cmd(8'h10 | 8'(c < 4 ? 8 + c : 10 + c) | 8'($urandom_range(1, 0) << 5),
        16'(cyc / 8 + 6));
      wt(n_s, c + 1);
      if (c < 4) rc(TIMER_FLAG_ADDR, 8'h0f, 8'(1 << c));
      rc(TIMER_FLAG_ADDR, 8'h3f, 8'h00);
    end
    chk(8'(n_a), 8'h01);
    for (c = 0; c < 8; c++) cmd(8'h40, 16'hffff);
    cmd(8'h30, 16'(cyc / 8 + 3));
    rc(OUT_STATUS_ADDR, 8'hc0, 8'hc0);
    repeat (100) @(posedge clk);
    chk({2'h0, tpin}, 8'h00);
    chk(8'(n_x), 8'h08);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(OUT_STATUS_ADDR, 8'hc0, 8'h00);
    chk({6'h0, toe}, 8'h00);
    repeat (80) @(posedge clk);
    rd(TIMER_ONE_ADDR, d);
    chk(8'(d >= 8'd9 && d <= 8'd11), 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
